// file: hw/tls_pkg.sv
/*
 Shared constants, states and frame helpers for the supervisor link.
 Assumes one 100 MHz clock on both ends.
*/
package tls_pkg;
   localparam int TEMP_W = 16;
   localparam int CNT_W = 34;
   localparam int BAUD_W = 16;
   localparam int FRAME_BITS = 26;
   localparam int CMD_W = 8;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint POLL_S = 60;
   localparam longint PERSIST_S = 20;
   localparam longint TRIP_HOLD_S = 6;
   localparam longint LIM_PERSIST_S = 60;
   localparam longint REPLY_TO_MS = 100;
   localparam longint POLL_CYC = POLL_S * CLK_HZ;
   localparam longint PERSIST_CYC = PERSIST_S * CLK_HZ;
   localparam longint TRIP_HOLD_CYC = TRIP_HOLD_S * CLK_HZ;
   localparam longint LIM_PERSIST_CYC = LIM_PERSIST_S * CLK_HZ;
   localparam longint REPLY_TO_CYC = (REPLY_TO_MS * CLK_HZ) / 1000;
   localparam logic [BAUD_W-1:0] BAUD_DIV = 16'h0364;
   localparam logic [CNT_W-1:0] CNT_ONE = 34'h000000001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 34'h000000000;
   localparam logic [BAUD_W-1:0] BAUD_ONE = 16'h0001;
   localparam logic [4:0] BITS_LAST = 5'h19;
   localparam logic [4:0] BITS_ALL = 5'h1a;
   localparam logic [4:0] BITS_ONE = 5'h01;
   localparam logic [FRAME_BITS-1:0] FRAME_IDLE = 26'h3ffffff;
   // Link commands
   localparam logic [CMD_W-1:0] CMD_UTL = 8'h01;
   localparam logic [CMD_W-1:0] CMD_LTL = 8'h02;
   localparam logic [CMD_W-1:0] CMD_QUERY = 8'h03;
   localparam logic [CMD_W-1:0] CMD_ACK = 8'h81;
   // Values after reset, and the pole imbalance limit
   localparam logic [TEMP_W-1:0] UTL_RST = 16'h009b;
   localparam logic [TEMP_W-1:0] LTL_RST = 16'hff9c;
   localparam logic [TEMP_W-1:0] SETPOINT_RST = 16'h0019;
   localparam logic [15:0] GF_LIMIT_MA = 16'h07d0;

   typedef enum logic [1:0] {TLS_LK_IDLE, TLS_LK_WAIT} tls_link_state_t;

   // Frame on the wire, LSB first: start 0, command, data, stop 1
   function automatic logic [FRAME_BITS-1:0] make_frame(input logic [CMD_W-1:0] cmd,
                                                         input logic [TEMP_W-1:0] data);
      make_frame = {1'b1, data, cmd, 1'b0};
   endfunction

   function automatic logic [CMD_W-1:0] frame_cmd(input logic [FRAME_BITS-1:0] f);
      frame_cmd = f[8:1];
   endfunction

   function automatic logic [TEMP_W-1:0] frame_data(input logic [FRAME_BITS-1:0] f);
      frame_data = f[24:9];
   endfunction
endpackage

// file: hw/tls_link_if.sv
/*
 Link between the main controller end and the limit and breaker end.
 Assumes both ends share the clock; the testbench connects the two modports.
*/
`timescale 1ns/10ps
interface tls_link_if;
   logic ctl_txd;
   logic lim_txd;
   logic ctl_trip_req;

   modport ctl
   (
      output ctl_txd,
      output ctl_trip_req,
      input lim_txd
   );

   modport lim
   (
      input ctl_txd,
      input ctl_trip_req,
      output lim_txd
   );
endinterface

// file: hw/tls_ctl_end.sv
/*
 Main controller end: limit forwarding, module polling, enable gating and trip timer.
 Assumes the far end answers every query with one acknowledge frame.
*/
// Function
// - Forward every written limit over serial link
// - Query limit module about once per minute
// - Missing reply raises missing module message
// - Upper limit write resends both limits
// - Setpoint accepted without any limit check
// - Out of limits drops heat or cool
// - Still out 20 s later: trip request
// - Breaker opens after 6 s continuous request
// - Tripped breaker stays open until manual reset
// - Limit module trips after 60 s out
// - Thermostat over temperature is a trip source
// - DC supply failure is a trip source
// - Pole imbalance above 2 A trips breaker
`timescale 1ns/10ps
module tls_ctl_end #(
   parameter logic [tls_pkg::CNT_W-1:0] POLL_CYC = tls_pkg::CNT_W'(tls_pkg::POLL_CYC),
   parameter logic [tls_pkg::CNT_W-1:0] PERSIST_CYC = tls_pkg::CNT_W'(tls_pkg::PERSIST_CYC),
   parameter logic [tls_pkg::CNT_W-1:0] REPLY_TO_CYC = tls_pkg::CNT_W'(tls_pkg::REPLY_TO_CYC),
   parameter logic [tls_pkg::BAUD_W-1:0] BAUD_DIV = tls_pkg::BAUD_DIV
)
(
   input wire logic clock,
   input wire logic reset,
   tls_link_if.ctl link,
   input wire logic limit_wr_upper,
   input wire logic limit_wr_lower,
   input wire logic [tls_pkg::TEMP_W-1:0] limit_value,
   input wire logic setpoint_wr,
   input wire logic [tls_pkg::TEMP_W-1:0] setpoint_value,
   input wire logic [tls_pkg::TEMP_W-1:0] chamber_temp,
   input wire logic heat_request,
   input wire logic cool_request,
   output logic heat_enable,
   output logic cool_enable,
   output logic [tls_pkg::TEMP_W-1:0] upper_temp_limit,
   output logic [tls_pkg::TEMP_W-1:0] lower_temp_limit,
   output logic [tls_pkg::TEMP_W-1:0] setpoint,
   output logic missing_limit_module_message,
   output logic trip_request,
   output logic reply_temp_valid,
   output logic [tls_pkg::TEMP_W-1:0] reply_temp
);
   tls_pkg::tls_link_state_t state;
   logic pend_upper, pend_lower, pend_query, tx_start, tx_busy, rx_busy, rx_valid;
   logic ack_seen, over_upper, under_lower, out_of_limits;
   logic [tls_pkg::CNT_W-1:0] poll_cnt, wait_cnt, persist_cnt;
   logic [tls_pkg::CMD_W-1:0] tx_cmd;
   logic [tls_pkg::TEMP_W-1:0] tx_data;
   logic [tls_pkg::FRAME_BITS-1:0] tx_sr, rx_sr;
   logic [4:0] tx_bits, rx_bits;
   logic [tls_pkg::BAUD_W-1:0] tx_baud, rx_baud;
   assign over_upper = $signed(chamber_temp) > $signed(upper_temp_limit);
   assign under_lower = $signed(chamber_temp) < $signed(lower_temp_limit);
   assign out_of_limits = over_upper || under_lower;
   assign ack_seen = rx_valid && (tls_pkg::frame_cmd(rx_sr) == tls_pkg::CMD_ACK);
   assign link.ctl_txd = tx_sr[0];
   assign link.ctl_trip_req = trip_request;
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         upper_temp_limit <= tls_pkg::UTL_RST;
         lower_temp_limit <= tls_pkg::LTL_RST;
         setpoint <= tls_pkg::SETPOINT_RST;
      end
      else
      begin
         if (limit_wr_upper)
            upper_temp_limit <= limit_value;
         if (limit_wr_lower)
            lower_temp_limit <= limit_value;
         if (setpoint_wr)
            setpoint <= setpoint_value;
      end
   end
   always_comb
   begin
      tx_start = 1'b0;
      tx_cmd = tls_pkg::CMD_QUERY;
      tx_data = tls_pkg::UTL_RST;
      if (state == tls_pkg::TLS_LK_IDLE && !tx_busy)
      begin
         if (pend_upper)
         begin
            tx_start = 1'b1;
            tx_cmd = tls_pkg::CMD_UTL;
            tx_data = upper_temp_limit;
         end
         else if (pend_lower)
         begin
            tx_start = 1'b1;
            tx_cmd = tls_pkg::CMD_LTL;
            tx_data = lower_temp_limit;
         end
         else if (pend_query)
            tx_start = 1'b1;
      end
   end
   // Both pending at reset so the limit module is synchronised at power up
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         pend_upper <= 1'b1;
         pend_lower <= 1'b1;
      end
      else
      begin
         if (limit_wr_upper)
            pend_upper <= 1'b1;
         else if (tx_start && tx_cmd == tls_pkg::CMD_UTL)
            pend_upper <= 1'b0;
         if (limit_wr_lower || limit_wr_upper)
            pend_lower <= 1'b1;
         else if (tx_start && tx_cmd == tls_pkg::CMD_LTL)
            pend_lower <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         poll_cnt <= tls_pkg::CNT_ZERO;
         pend_query <= 1'b0;
      end
      else
      begin
         poll_cnt <= (poll_cnt == POLL_CYC - tls_pkg::CNT_ONE) ? tls_pkg::CNT_ZERO : poll_cnt + tls_pkg::CNT_ONE;
         if (poll_cnt == POLL_CYC - tls_pkg::CNT_ONE)
            pend_query <= 1'b1;
         else if (tx_start && tx_cmd == tls_pkg::CMD_QUERY)
            pend_query <= 1'b0;
      end
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         state <= tls_pkg::TLS_LK_IDLE;
         wait_cnt <= tls_pkg::CNT_ZERO;
         missing_limit_module_message <= 1'b0;
         reply_temp_valid <= 1'b0;
         reply_temp <= tls_pkg::UTL_RST;
      end
      else
      begin
         reply_temp_valid <= 1'b0;
         wait_cnt <= tls_pkg::CNT_ZERO;
         case (state)
            tls_pkg::TLS_LK_IDLE:
               if (tx_start && tx_cmd == tls_pkg::CMD_QUERY)
                  state <= tls_pkg::TLS_LK_WAIT;
            tls_pkg::TLS_LK_WAIT:
            begin
               wait_cnt <= wait_cnt + tls_pkg::CNT_ONE;
               if (ack_seen || wait_cnt == REPLY_TO_CYC - tls_pkg::CNT_ONE)
                  state <= tls_pkg::TLS_LK_IDLE;
               if (ack_seen)
               begin
                  missing_limit_module_message <= 1'b0;
                  reply_temp_valid <= 1'b1;
                  reply_temp <= tls_pkg::frame_data(rx_sr);
               end
               else if (wait_cnt == REPLY_TO_CYC - tls_pkg::CNT_ONE)
                  missing_limit_module_message <= 1'b1;
            end
            default: state <= tls_pkg::TLS_LK_IDLE;
         endcase
      end
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tx_sr <= tls_pkg::FRAME_IDLE;
         tx_bits <= 5'h00;
         tx_baud <= 16'h0000;
         tx_busy <= 1'b0;
      end
      else if (tx_start)
      begin
         tx_sr <= tls_pkg::make_frame(tx_cmd, tx_data);
         tx_bits <= tls_pkg::BITS_ALL;
         tx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
         tx_busy <= 1'b1;
      end
      else if (tx_busy)
      begin
         if (tx_baud == 16'h0000)
         begin
            tx_sr <= {1'b1, tx_sr[tls_pkg::FRAME_BITS-1:1]};
            tx_bits <= tx_bits - tls_pkg::BITS_ONE;
            tx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
            tx_busy <= tx_bits != tls_pkg::BITS_ONE;
         end
         else
            tx_baud <= tx_baud - tls_pkg::BAUD_ONE;
      end
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rx_busy <= 1'b0;
         rx_sr <= tls_pkg::FRAME_IDLE;
         rx_bits <= 5'h00;
         rx_baud <= 16'h0000;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_busy)
         begin
            rx_busy <= !link.lim_txd;
            rx_bits <= 5'h00;
            rx_baud <= BAUD_DIV >> 1;
         end
         else if (rx_baud == 16'h0000)
         begin
            rx_sr <= {link.lim_txd, rx_sr[tls_pkg::FRAME_BITS-1:1]};
            rx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
            rx_bits <= rx_bits + tls_pkg::BITS_ONE;
            // A frame with a bad start or stop bit is dropped
            rx_busy <= rx_bits != tls_pkg::BITS_LAST;
            rx_valid <= (rx_bits == tls_pkg::BITS_LAST) && link.lim_txd && !rx_sr[1];
         end
         else
            rx_baud <= rx_baud - tls_pkg::BAUD_ONE;
      end
   end
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         heat_enable <= 1'b0;
         cool_enable <= 1'b0;
      end
      else
      begin
         heat_enable <= heat_request && !over_upper;
         cool_enable <= cool_request && !under_lower;
      end
   end
   // Persistence timer saturates so the request holds while the excursion lasts
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         persist_cnt <= tls_pkg::CNT_ZERO;
         trip_request <= 1'b0;
      end
      else
      begin
         if (!out_of_limits)
            persist_cnt <= tls_pkg::CNT_ZERO;
         else if (persist_cnt != PERSIST_CYC - tls_pkg::CNT_ONE)
            persist_cnt <= persist_cnt + tls_pkg::CNT_ONE;
         trip_request <= out_of_limits && (persist_cnt == PERSIST_CYC - tls_pkg::CNT_ONE);
      end
   end
endmodule // tls_ctl_end

// file: hw/tls_lim_end.sv
/*
 Far end: redundant limit module and breaker trip module.
 Assumes whole frames on the link and pole currents in milliamps.
*/
`timescale 1ns/10ps
module tls_lim_end #(
   parameter logic [tls_pkg::CNT_W-1:0] LIM_PERSIST_CYC = tls_pkg::CNT_W'(tls_pkg::LIM_PERSIST_CYC),
   parameter logic [tls_pkg::CNT_W-1:0] TRIP_HOLD_CYC = tls_pkg::CNT_W'(tls_pkg::TRIP_HOLD_CYC),
   parameter logic [tls_pkg::BAUD_W-1:0] BAUD_DIV = tls_pkg::BAUD_DIV
)
(
   input wire logic clock,
   input wire logic reset,
   tls_link_if.lim link,
   input wire logic [tls_pkg::TEMP_W-1:0] lim_temp,
   input wire logic thermostat_over,
   input wire logic dc_supply_ok,
   input wire logic [15:0] pole_a_ma,
   input wire logic [15:0] pole_b_ma,
   input wire logic manual_reset,
   output logic breaker_closed,
   output logic ground_fault_trip,
   output logic limit_trip_request,
   output logic [tls_pkg::TEMP_W-1:0] lim_upper,
   output logic [tls_pkg::TEMP_W-1:0] lim_lower
);
   logic breaker_open, trip_any, imbalance, lim_out, reply_pend, tx_busy, rx_busy, rx_valid;
   logic [15:0] pole_diff;
   logic [tls_pkg::CNT_W-1:0] lim_cnt, hold_cnt;
   logic [tls_pkg::FRAME_BITS-1:0] tx_sr, rx_sr;
   logic [4:0] tx_bits, rx_bits;
   logic [tls_pkg::BAUD_W-1:0] tx_baud, rx_baud;

   assign pole_diff = (pole_a_ma > pole_b_ma) ? pole_a_ma - pole_b_ma : pole_b_ma - pole_a_ma;
   assign imbalance = pole_diff > tls_pkg::GF_LIMIT_MA;
   assign lim_out = ($signed(lim_temp) > $signed(lim_upper)) || ($signed(lim_temp) < $signed(lim_lower));
   assign trip_any = link.ctl_trip_req || limit_trip_request || thermostat_over || !dc_supply_ok;
   assign breaker_closed = !breaker_open;
   assign link.lim_txd = tx_sr[0];

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         lim_upper <= tls_pkg::UTL_RST;
         lim_lower <= tls_pkg::LTL_RST;
         reply_pend <= 1'b0;
      end
      else
      begin
         if (rx_valid && tls_pkg::frame_cmd(rx_sr) == tls_pkg::CMD_UTL)
            lim_upper <= tls_pkg::frame_data(rx_sr);
         if (rx_valid && tls_pkg::frame_cmd(rx_sr) == tls_pkg::CMD_LTL)
            lim_lower <= tls_pkg::frame_data(rx_sr);
         if (rx_valid && tls_pkg::frame_cmd(rx_sr) == tls_pkg::CMD_QUERY)
            reply_pend <= 1'b1;
         else if (!tx_busy)
            reply_pend <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         tx_sr <= tls_pkg::FRAME_IDLE;
         tx_bits <= 5'h00;
         tx_baud <= 16'h0000;
         tx_busy <= 1'b0;
      end
      else if (reply_pend && !tx_busy)
      begin
         tx_sr <= tls_pkg::make_frame(tls_pkg::CMD_ACK, lim_temp);
         tx_bits <= tls_pkg::BITS_ALL;
         tx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
         tx_busy <= 1'b1;
      end
      else if (tx_busy)
      begin
         if (tx_baud == 16'h0000)
         begin
            tx_sr <= {1'b1, tx_sr[tls_pkg::FRAME_BITS-1:1]};
            tx_bits <= tx_bits - tls_pkg::BITS_ONE;
            tx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
            if (tx_bits == tls_pkg::BITS_ONE)
               tx_busy <= 1'b0;
         end
         else
            tx_baud <= tx_baud - tls_pkg::BAUD_ONE;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         rx_busy <= 1'b0;
         rx_sr <= tls_pkg::FRAME_IDLE;
         rx_bits <= 5'h00;
         rx_baud <= 16'h0000;
         rx_valid <= 1'b0;
      end
      else
      begin
         rx_valid <= 1'b0;
         if (!rx_busy)
         begin
            if (!link.ctl_txd)
            begin
               rx_busy <= 1'b1;
               rx_bits <= 5'h00;
               rx_baud <= BAUD_DIV >> 1;
            end
         end
         else if (rx_baud == 16'h0000)
         begin
            rx_sr <= {link.ctl_txd, rx_sr[tls_pkg::FRAME_BITS-1:1]};
            rx_baud <= BAUD_DIV - tls_pkg::BAUD_ONE;
            rx_bits <= rx_bits + tls_pkg::BITS_ONE;
            if (rx_bits == tls_pkg::BITS_LAST)
            begin
               rx_busy <= 1'b0;
               rx_valid <= link.ctl_txd && !rx_sr[1];
            end
         end
         else
            rx_baud <= rx_baud - tls_pkg::BAUD_ONE;
      end
   end

   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         lim_cnt <= tls_pkg::CNT_ZERO;
         limit_trip_request <= 1'b0;
      end
      else
      begin
         if (!lim_out)
            lim_cnt <= tls_pkg::CNT_ZERO;
         else if (lim_cnt != LIM_PERSIST_CYC - tls_pkg::CNT_ONE)
            lim_cnt <= lim_cnt + tls_pkg::CNT_ONE;
         limit_trip_request <= lim_out && (lim_cnt == LIM_PERSIST_CYC - tls_pkg::CNT_ONE);
      end
   end

   // Breaker: any gap in the request restarts the hold; the trip latch wins over the reset handle
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
      begin
         hold_cnt <= tls_pkg::CNT_ZERO;
         breaker_open <= 1'b0;
         ground_fault_trip <= 1'b0;
      end
      else
      begin
         if (!trip_any)
            hold_cnt <= tls_pkg::CNT_ZERO;
         else if (hold_cnt != TRIP_HOLD_CYC - tls_pkg::CNT_ONE)
            hold_cnt <= hold_cnt + tls_pkg::CNT_ONE;
         if ((trip_any && hold_cnt == TRIP_HOLD_CYC - tls_pkg::CNT_ONE) || imbalance)
            breaker_open <= 1'b1;
         else if (manual_reset)
            breaker_open <= 1'b0;
         if (imbalance)
            ground_fault_trip <= 1'b1;
         else if (manual_reset)
            ground_fault_trip <= 1'b0;
      end
   end
endmodule // tls_lim_end

// file: verif/tls_link_sva.sv
/*
 Checker for the link and the ports of both ends.
 Assumes one clock and one reset.
*/
`timescale 1ns/10ps
module tls_link_sva #(
   parameter int PERSIST = 500
)
(
   input wire logic clock,
   input wire logic reset,
   input wire logic ctl_trip_req,
   input wire logic [15:0] chamber_temp,
   input wire logic [15:0] upper_temp_limit,
   input wire logic [15:0] lower_temp_limit,
   input wire logic heat_enable,
   input wire logic cool_enable,
   input wire logic limit_wr_upper,
   input wire logic [15:0] limit_value,
   input wire logic setpoint_wr,
   input wire logic [15:0] setpoint_value,
   input wire logic [15:0] setpoint,
   input wire logic [15:0] lim_upper,
   input wire logic breaker_closed,
   input wire logic manual_reset
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   logic hot;
   logic cold;
   logic [15:0] out_cnt;
   assign hot = $signed(chamber_temp) > $signed(upper_temp_limit);
   assign cold = $signed(chamber_temp) < $signed(lower_temp_limit);
   // Run length of out-of-limit cycles; one cycle back inside clears it
   always_ff @(posedge clock or posedge reset)
   begin
      if (reset)
         out_cnt <= 16'h0000;
      else if (!(hot || cold))
         out_cnt <= 16'h0000;
      else
         out_cnt <= out_cnt + 16'h0001;
   end
   property p_heat_off;
      hot |=> !heat_enable;
   endproperty
   a_heat_off: assert property (p_heat_off) else $error("heat enable on above limit");
   property p_cool_off;
      cold |=> !cool_enable;
   endproperty
   a_cool_off: assert property (p_cool_off) else $error("cool enable on below limit");
   property p_trip_early;
      $rose(ctl_trip_req) |-> int'(out_cnt) >= PERSIST - 2;
   endproperty
   a_trip_early: assert property (p_trip_early) else $error("trip request too early");
   property p_trip_late;
      int'(out_cnt) > PERSIST + 2 |-> ctl_trip_req;
   endproperty
   a_trip_late: assert property (p_trip_late) else $error("trip request missing");
   property p_upper_wr;
      limit_wr_upper |=> upper_temp_limit == $past(limit_value);
   endproperty
   a_upper_wr: assert property (p_upper_wr) else $error("upper limit not stored");
   property p_setpoint;
      setpoint_wr |=> setpoint == $past(setpoint_value);
   endproperty
   a_setpoint: assert property (p_setpoint) else $error("setpoint not taken");
   property p_lim_copy;
      $changed(lim_upper) |-> lim_upper == upper_temp_limit;
   endproperty
   a_lim_copy: assert property (p_lim_copy) else $error("far copy differs");
   property p_brk_stay;
      !breaker_closed && !manual_reset |=> !breaker_closed;
   endproperty
   a_brk_stay: assert property (p_brk_stay) else $error("breaker closed itself");
   c_trip: cover property ($rose(ctl_trip_req));
   c_brk: cover property ($fell(breaker_closed));
   c_sync: cover property ($changed(lim_upper));
endmodule // tls_link_sva

// file: verif/tb_top.sv
/*
 Bench: both ends on one link, plus a controller with a silent far end.
 Assumes shortened counts.
*/
`timescale 1ns/10ps
module tb_top;
   logic clock, reset, limit_wr_upper, limit_wr_lower, setpoint_wr, heat_request, cool_request;
   logic thermostat_over, dc_supply_ok, manual_reset, heat_enable, cool_enable, trip_request;
   logic reply_temp_valid, missing_limit_module_message, msg_b, breaker_closed, ground_fault_trip;
   logic limit_trip_request, b_he, b_ce, b_tr, b_rv;
   logic [15:0] b_up, b_lo, b_sp, b_rt;
   logic [15:0] limit_value, setpoint_value, chamber_temp, lim_temp, pole_a_ma, pole_b_ma;
   logic [15:0] upper_temp_limit, lower_temp_limit, setpoint, reply_temp, lim_upper, lim_lower;
   logic [25:0] f;
   int miscompares = 0;
   int comparisons = 0;
   tls_link_if link();
   tls_link_if link_b();
   // Silent far end: every query goes unanswered
   assign link_b.lim_txd = 1'b1;
   tls_ctl_end #(.POLL_CYC(34'h0000007d0), .PERSIST_CYC(34'h0000001f4), .REPLY_TO_CYC(34'h000000258),
      .BAUD_DIV(16'h0008)) u_tls_ctl_end
   (.clock, .reset, .link, .limit_wr_upper, .limit_wr_lower, .limit_value, .setpoint_wr, .setpoint_value,
      .chamber_temp, .heat_request, .cool_request, .heat_enable, .cool_enable, .upper_temp_limit,
      .lower_temp_limit, .setpoint, .missing_limit_module_message, .trip_request, .reply_temp_valid, .reply_temp);
   tls_ctl_end #(.POLL_CYC(34'h0000007d0), .PERSIST_CYC(34'h0000001f4), .REPLY_TO_CYC(34'h000000258),
      .BAUD_DIV(16'h0008)) u_tls_ctl_end_b
   (.clock, .reset, .link(link_b), .limit_wr_upper, .limit_wr_lower, .limit_value, .setpoint_wr,
      .setpoint_value, .chamber_temp, .heat_request, .cool_request, .heat_enable(b_he), .cool_enable(b_ce),
      .upper_temp_limit(b_up), .lower_temp_limit(b_lo), .setpoint(b_sp), .missing_limit_module_message(msg_b),
      .trip_request(b_tr), .reply_temp_valid(b_rv), .reply_temp(b_rt));
   tls_lim_end #(.LIM_PERSIST_CYC(34'h000000320), .TRIP_HOLD_CYC(34'h0000000c8), .BAUD_DIV(16'h0008)) u_tls_lim_end
   (.clock, .reset, .link, .lim_temp, .thermostat_over, .dc_supply_ok, .pole_a_ma, .pole_b_ma, .manual_reset,
      .breaker_closed, .ground_fault_trip, .limit_trip_request, .lim_upper, .lim_lower);
   tls_link_sva #(.PERSIST(500)) u_tls_link_sva
   (.clock, .reset, .ctl_trip_req(link.ctl_trip_req), .chamber_temp, .upper_temp_limit, .lower_temp_limit,
      .heat_enable, .cool_enable, .limit_wr_upper, .limit_value, .setpoint_wr, .setpoint_value, .setpoint,
      .lim_upper, .breaker_closed, .manual_reset);
   always #5 clock = ~clock;
   task automatic report_and_stop();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [25:0] s, input logic [25:0] e);
      comparisons++;
      if (s !== e)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wt(ref logic s, input logic v, input int n);
      for (int i = 0; i < n && s !== v; i++)
         @(negedge clock);
      if (s !== v)
      begin
         miscompares++;
         $display("BAD wait expected %b seen %b", v, s);
         report_and_stop();
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task automatic wr(input int k, input logic [15:0] v);
      @(posedge clock);
      limit_value <= v;
      setpoint_value <= v;
      limit_wr_upper <= (k == 0);
      limit_wr_lower <= (k == 1);
      setpoint_wr <= (k == 2);
      @(posedge clock);
      limit_wr_upper <= 1'b0;
      limit_wr_lower <= 1'b0;
      setpoint_wr <= 1'b0;
   endtask
   // Samples each bit in its middle, eight cycles apart
   task automatic rx(input logic [7:0] c, input logic [15:0] d);
      wt(link.ctl_txd, 1'b0, 3000);
      repeat (4) @(negedge clock);
      f[0] = link.ctl_txd;
      for (int i = 1; i < 26; i++)
      begin
         repeat (8) @(negedge clock);
         f[i] = link.ctl_txd;
      end
      chk("frame", f, {1'b1, d, c, 1'b0});
   endtask
   task automatic mrst();
      @(posedge clock);
      manual_reset <= 1'b1;
      cyc(3);
      @(posedge clock);
      manual_reset <= 1'b0;
      cyc(2);
      chk("breaker", breaker_closed, 1'b1);
   endtask
   initial
   begin
      {clock, limit_wr_upper, limit_wr_lower, setpoint_wr, thermostat_over, manual_reset} = 6'h00;
      {reset, heat_request, cool_request, dc_supply_ok} = 4'hf;
      {limit_value, setpoint_value, chamber_temp, lim_temp} = {16'h0000, 16'h0000, 16'h0019, 16'h0030};
      {pole_a_ma, pole_b_ma} = {16'h03e8, 16'h03e8};
      cyc(2);
      chk("upper", upper_temp_limit, 16'h009b);
      chk("lower", lower_temp_limit, 16'hff9c);
      chk("txd", link.ctl_txd, 1'b1);
      @(posedge clock);
      reset <= 1'b0;
      rx(8'h01, 16'h009b);
      rx(8'h02, 16'hff9c);
      wr(1, 16'hfff6);
      rx(8'h02, 16'hfff6);
      wr(0, 16'h00c8);
      rx(8'h01, 16'h00c8);
      rx(8'h02, 16'hfff6);
      cyc(4);
      chk("lim_upper", lim_upper, 16'h00c8);
      chk("lim_lower", lim_lower, 16'hfff6);
      wr(2, 16'h0190);
      cyc(1);
      chk("setpoint", setpoint, 16'h0190);
      $display("test link done");
      @(posedge clock);
      chamber_temp <= 16'h00d0;
      cyc(2);
      chk("heat", heat_enable, 1'b0);
      chk("cool", cool_enable, 1'b1);
      cyc(300);
      @(posedge clock);
      chamber_temp <= 16'h0020;
      cyc(300);
      chk("trip", trip_request, 1'b0);
      chk("heat", heat_enable, 1'b1);
      @(posedge clock);
      chamber_temp <= 16'hffe0;
      cyc(2);
      chk("cool", cool_enable, 1'b0);
      cyc(475);
      chk("trip", trip_request, 1'b0);
      wt(trip_request, 1'b1, 40);
      chk("wire trip", link.ctl_trip_req, 1'b1);
      cyc(180);
      chk("breaker", breaker_closed, 1'b1);
      wt(breaker_closed, 1'b0, 40);
      @(posedge clock);
      chamber_temp <= 16'h0020;
      cyc(5);
      chk("breaker", breaker_closed, 1'b0);
      mrst();
      $display("test trip done");
      wt(reply_temp_valid, 1'b1, 2500);
      chk("reply", reply_temp, 16'h0030);
      chk("message", missing_limit_module_message, 1'b0);
      wt(msg_b, 1'b1, 800);
      @(posedge clock);
      lim_temp <= 16'h0100;
      cyc(780);
      chk("lim trip", limit_trip_request, 1'b0);
      wt(limit_trip_request, 1'b1, 40);
      wt(breaker_closed, 1'b0, 260);
      @(posedge clock);
      lim_temp <= 16'h0030;
      cyc(3);
      mrst();
      for (int i = 0; i < 2; i++)
      begin
         @(posedge clock);
         thermostat_over <= (i == 0);
         dc_supply_ok <= (i == 0);
         cyc(190);
         chk("breaker", breaker_closed, 1'b1);
         wt(breaker_closed, 1'b0, 30);
         @(posedge clock);
         {thermostat_over, dc_supply_ok} <= 2'h1;
         mrst();
      end
      $display("test sources done");
      @(posedge clock);
      pole_a_ma <= 16'h0bb8;
      cyc(3);
      chk("ground fault", ground_fault_trip, 1'b0);
      @(posedge clock);
      pole_a_ma <= 16'h0bb9;
      cyc(2);
      chk("ground fault", ground_fault_trip, 1'b1);
      chk("breaker", breaker_closed, 1'b0);
      chk("twin upper", b_up, 16'h00c8);
      chk("twin lower", b_lo, 16'hfff6);
      chk("twin setpoint", b_sp, 16'h0190);
      chk("twin reply", b_rt, 16'h009b);
      chk("twin enables", {b_he, b_ce, b_tr, b_rv}, 4'hc);
      $display("test ground fault done");
      report_and_stop();
   end
endmodule // tb_top
